// *** verification/sgx_gateway_props.sv ***
// checker on the serial gateway ports
`timescale 1ns/10ps
`default_nettype none
module sgx_gateway_props #(
    parameter IMG_BYTES  = 8,
    parameter BUF_BYTES  = 1024,
    parameter GAP_CYCLES = 50
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   collective_sel,
    input wire logic [8*IMG_BYTES-1:0] out_image,
    input wire logic                   out_image_valid,
    input wire logic [8*IMG_BYTES-1:0] in_image,
    input wire logic [7:0]             rx_data,
    input wire logic                   rx_valid,
    input wire logic [7:0]             tx_data,
    input wire logic                   tx_valid,
    input wire logic                   tx_ready
);
    logic [7:0] since_pulse_reg;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // cycles since the last host image, saturating
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            since_pulse_reg <= 8'hff;
        else if (out_image_valid)
            since_pulse_reg <= 8'h00;
        else if (since_pulse_reg != 8'hff)
            since_pulse_reg <= since_pulse_reg + 8'h01;
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    tx_byte_held_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed while stalled");
    tx_no_zero_a: assert property (tx_valid |-> tx_data != 8'h00)
        else $error("zero byte sent to device");
    mode_echo_a: assert property (1'b1 |=> in_image[4] == $past(collective_sel))
        else $error("mode status not echoed");
    cmd_status_a: assert property (out_image_valid ##1 !out_image_valid
        |=> in_image[5] == $past(out_image[0], 2))
        else $error("command mode status wrong");
    count_bound_a: assert property (in_image[15:8] <= IMG_BYTES - 2)
        else $error("byte count above image capacity");
    printable_only_a: assert property (!collective_sel && $changed(in_image[0])
        && in_image[15:8] != 8'h00 |-> in_image[23:16] >= 8'h20)
        else $error("control character published");
    pull_only_a: assert property (collective_sel && $past(collective_sel)
        && $changed(in_image[63:16]) |-> since_pulse_reg < 8'h10)
        else $error("buffered data pushed without request");
    pend_transp_a: assert property (!collective_sel && !$past(collective_sel)
        |-> !in_image[3])
        else $error("pending flag in transparent mode");
endmodule

bind sgx_gateway sgx_gateway_props #(
    .IMG_BYTES(IMG_BYTES), .BUF_BYTES(BUF_BYTES), .GAP_CYCLES(GAP_CYCLES)
) u_props (
    .clk(clk), .rst_n(rst_n), .collective_sel(collective_sel), .out_image(out_image),
    .out_image_valid(out_image_valid), .in_image(in_image), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
);
`default_nettype wire

// *** verification/sgx_serial_dev.sv ***
// serial end device model: takes tx bytes, sends rx bytes
`timescale 1ns/10ps
`default_nettype none
module sgx_serial_dev (
    input  wire logic       clk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic       tx_ready,
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid
);
    logic       slow;
    logic [7:0] got[$];
    initial begin
        slow = 1'b0;
        tx_ready = 1'b0;
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    // ----------------------------------------------------------------
    // receiver side; slow mode accepts only every other cycle
    // ----------------------------------------------------------------
    always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
    // ----------------------------------------------------------------
    // sender side; released line shows the inverse, not a stale byte
    // ----------------------------------------------------------------
    task send(input logic [7:0] b);
        @(negedge clk);
        rx_data = b;
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_data = ~b;
    endtask
    task send_str(input int n, input logic [63:0] s);
        for (int i = 0; i < n; i++) send(s[8*i+:8]);
    endtask
    // idle spacing between unframed telegrams
    task gap(input int cycles);
        repeat (cycles) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** verification/tb_serial_gateway_data_exchange.sv ***
// testbench for the serial gateway data exchange block
`timescale 1ns/10ps
`default_nettype none
module tb_serial_gateway_data_exchange;
    localparam int GAP = 50;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        collective_sel = 1'b0;
    logic [63:0] out_image = 64'h0;
    logic        out_image_valid = 1'b0;
    logic [63:0] in_image;
    logic [7:0]  tx_data;
    logic [7:0]  rx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic        rx_valid;
    logic [7:0]  c0 = 8'h00;
    logic [7:0]  c1 = 8'h00;
    logic [63:0] cmd_chars = 64'h5351_4D50_5248_2B76;
    int          error_cnt = 0;
    int          check_count = 0;
    always #4 clk = ~clk;
    // small buffer so overflow is reachable in a short run
    sgx_gateway #(.IMG_BYTES(8), .BUF_BYTES(8), .GAP_CYCLES(GAP)) dut (
        .clk(clk), .rst_n(rst_n), .collective_sel(collective_sel), .out_image(out_image),
        .out_image_valid(out_image_valid), .in_image(in_image), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    sgx_serial_dev dev (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task print_verdict;
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task host(input logic [47:0] d);
        @(negedge clk);
        out_image = {d, c1, c0};
        out_image_valid = 1'b1;
        @(negedge clk);
        out_image_valid = 1'b0;
    endtask
    // bounded wait for n bytes, then a quiet tail to catch extras
    task exp_tx(input int n, input logic [63:0] e);
        int i;
        i = 0;
        while (dev.got.size() < n && i < 300) begin
            @(negedge clk);
            i++;
        end
        repeat (12) @(negedge clk);
        chk("tx count", n, dev.got.size());
        for (i = 0; i < n && i < dev.got.size(); i++) chk("tx byte", e[8*i+:8], dev.got[i]);
        dev.got.delete();
    endtask
    task settle_chk(input string nm, input logic [63:0] e);
        repeat (16) @(negedge clk);
        chk(nm, e, in_image);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("reset image", 64'h0, in_image);
        dev.send_str(5, 64'h0043_0142_41);
        settle_chk("rx telegram", 64'h0000_0043_4241_0301);
        dev.gap(GAP + 20);
        dev.send_str(7, 64'h0047_4645_4443_4241);
        dev.gap(GAP + 20);
        chk("rx overlong", 64'h4645_4443_4241_0600, in_image);
        host(48'h2B);
        exp_tx(1, 64'h2B);
        host(48'h2B);
        exp_tx(0, 64'h0);
        c0 = 8'h80;
        host(48'h2B);
        exp_tx(1, 64'h2B);
        c0 = 8'h81;
        host(48'h0);
        exp_tx(0, 64'h0);
        for (int i = 0; i < 8; i++) begin
            host(48'h1 << i);
            exp_tx(4, {32'h0, 16'h0A0D, cmd_chars[8*i+:8], 8'h02});
            host(48'h0);
            exp_tx(i == 1 ? 4 : 0, 64'h0A0D_2D02);
        end
        c0 = 8'h80;
        host(48'h0);
        collective_sel = 1'b1;
        host(48'h2B);
        exp_tx(1, 64'h2B);
        dev.slow = 1'b1;
        c1 = 8'h08;
        host(48'h4102);
        exp_tx(0, 64'h0);
        c1 = 8'h00;
        host(48'h0A0D);
        exp_tx(0, 64'h0);
        c1 = 8'h08;
        host(48'h4746_4544_4342);
        exp_tx(0, 64'h0);
        c1 = 8'h0C;
        host(48'h4746_4544_4342);
        exp_tx(4, 64'h0A0D_4102);
        c1 = 8'h08;
        host(48'h4746_4544_4342);
        exp_tx(0, 64'h0);
        dev.slow = 1'b0;
        dev.send_str(8, 64'h0A0D_4544_4342_4102);
        repeat (4) @(negedge clk);
        chk("status wait", 64'h18, {56'h0, in_image[7:0]});
        c1 = 8'h09;
        host(48'h4746_4544_4342);
        settle_chk("block one", 64'h4544_4342_4102_0619);
        c1 = 8'h08;
        host(48'h4746_4544_4342);
        settle_chk("block two", 64'h0000_0000_0A0D_0210);
        c1 = 8'h09;
        host(48'h4746_4544_4342);
        settle_chk("final ack", 64'h10);
        print_verdict();
    end
    initial begin
        #(8 * 20000);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire

// *** verilog/sgx_defs.vh ***
// constants for the serial gateway data exchange block
`ifndef SGX_DEFS_VH
`define SGX_DEFS_VH

// ----------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------
`define SGX_IMG_BYTES      8
`define SGX_BUF_BYTES      1024
`define SGX_GAP_MS         20
`define SGX_CLK_KHZ        125000

// ----------------------------------------------------------------
// output control byte 0 / 1 bit positions
// ----------------------------------------------------------------
`define SGX_C0_CMD_MODE    0
`define SGX_C0_REPEAT      7
`define SGX_C1_READ_ACK    0
`define SGX_C1_SEND_TXBUF  2
`define SGX_C1_COPY_TXBUF  3

// ----------------------------------------------------------------
// input status byte 0 bit positions, reset values
// ----------------------------------------------------------------
`define SGX_S0_BLOCK_RX    0
`define SGX_S0_PENDING     3
`define SGX_S0_COLLECTIVE  4
`define SGX_S0_CMD_ACTIVE  5
`define SGX_CTL_RESET      8'h00

// ----------------------------------------------------------------
// framing characters
// ----------------------------------------------------------------
`define SGX_STX            8'h02
`define SGX_CR             8'h0D
`define SGX_LF             8'h0A
`define SGX_CTRL_LIMIT     8'h20
`define SGX_GATE_OFF_CHAR  8'h2D

`endif

// *** verilog/sgx_gateway.v ***
// process image to serial gateway: transparent, collective and command modes
`timescale 1ns/10ps
`default_nettype none
`include "sgx_defs.vh"

// Function
// - host picks transparent or collective; transparent after reset.
// - zero byte ends telegram; control characters dropped in transparent mode.
// - collective: received data buffered, pending flag raised, sent only on request.
// - collective: framing characters passed to host with payload.
// - staging buffer holds 1 kByte.
// - collective without copy toggle: output data goes straight to serial port.
// - collective read waits for host read-acknowledge toggle.
// - each read-ack toggle while pending presents next block.
// - on reception toggle block-received bit and report valid byte count.
// - byte count binary; pending at status 0.3, read-ack at control 1.0.
// - copy toggle change appends output data to transmit buffer.
// - send toggle change drains transmit buffer in order, leaves it empty.
// - command mode is bit 0 of control byte 0, any exchange mode.
// - command mode blocks direct and copied host data; a send toggle still drains the transmit buffer; receive path unchanged.
// - command bit set sends its character framed by STX and CR LF.
// - device answers to commands pass to host through the normal receive path, gap framed or held for read-ack.
module sgx_gateway #(
    parameter IMG_BYTES  = `SGX_IMG_BYTES,
    parameter BUF_BYTES  = `SGX_BUF_BYTES,
    parameter GAP_CYCLES = `SGX_GAP_MS * `SGX_CLK_KHZ
) (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   collective_sel,
    input  wire [8*IMG_BYTES-1:0] out_image,
    input  wire                   out_image_valid,
    output reg  [8*IMG_BYTES-1:0] in_image,
    input  wire [7:0]             rx_data,
    input  wire                   rx_valid,
    output reg  [7:0]             tx_data,
    output reg                    tx_valid,
    input  wire                   tx_ready
);
    localparam DATA_BYTES = IMG_BYTES - 2;
    localparam PW         = $clog2(BUF_BYTES);
    localparam CW         = PW + 1;
    localparam IW         = $clog2(IMG_BYTES) + 1;

    localparam ST_IDLE    = 3'd0;
    localparam ST_DIRECT  = 3'd1;
    localparam ST_APPEND  = 3'd2;
    localparam ST_CMD     = 3'd3;
    localparam ST_SEND    = 3'd4;

    // device-specific single character commands, one per data bit 2.x
    function [7:0] cmd_char;
        input [3:0] idx;
        begin
            case (idx)
                4'd0:    cmd_char = 8'h76;
                4'd1:    cmd_char = 8'h2B;
                4'd2:    cmd_char = 8'h48;
                4'd3:    cmd_char = 8'h52;
                4'd4:    cmd_char = 8'h50;
                4'd5:    cmd_char = 8'h4D;
                4'd6:    cmd_char = 8'h51;
                4'd7:    cmd_char = 8'h53;
                default: cmd_char = `SGX_GATE_OFF_CHAR;
            endcase
        end
    endfunction

    function [7:0] img_byte;
        input [8*IMG_BYTES-1:0] img;
        input [IW-1:0]          idx;
        begin
            img_byte = img[8*idx +: 8];
        end
    endfunction

    // ----------------------------------------------------------------
    // host side registers
    // ----------------------------------------------------------------
    reg  [7:0]             output_control_byte_zero_reg;
    reg  [7:0]             output_control_byte_one_reg;
    reg  [8*IMG_BYTES-1:0] out_snap_reg;
    reg  [2:0]             state_reg;
    reg  [IW-1:0]          idx_reg;
    reg  [1:0]             phase_reg;
    reg                    direct_pend_reg;
    reg                    append_pend_reg;
    reg                    send_pend_reg;
    reg  [8:0]             cmd_pend_reg;
    reg  [3:0]             cmd_idx_reg;
    reg  [7:0]             txbuf [0:BUF_BYTES-1];
    reg  [CW-1:0]          txbuf_cnt_reg;
    reg  [CW-1:0]          txbuf_rd_reg;

    wire [7:0]  img0 = out_image[7:0];
    wire [7:0]  img1 = out_image[15:8];
    wire [7:0]  img2 = out_image[23:16];
    wire        cmd_mode   = output_control_byte_zero_reg[`SGX_C0_CMD_MODE];
    // edges count only against an image that was itself in command mode
    wire [7:0]  old2 = cmd_mode ? out_snap_reg[23:16] : 8'h00;
    wire        copy_tgl   = img1[`SGX_C1_COPY_TXBUF] ^
                             output_control_byte_one_reg[`SGX_C1_COPY_TXBUF];
    wire        send_tgl   = img1[`SGX_C1_SEND_TXBUF] ^
                             output_control_byte_one_reg[`SGX_C1_SEND_TXBUF];
    wire        rack_tgl   = img1[`SGX_C1_READ_ACK] ^
                             output_control_byte_one_reg[`SGX_C1_READ_ACK];
    wire        repeat_tgl = img0[`SGX_C0_REPEAT] ^
                             output_control_byte_zero_reg[`SGX_C0_REPEAT];
    wire        data_chg   = out_image[8*IMG_BYTES-1:16] != out_snap_reg[8*IMG_BYTES-1:16];
    wire        cur_zero   = img_byte(out_snap_reg, idx_reg) == 8'h00;
    wire        img_end    = (idx_reg == IMG_BYTES[IW-1:0]) || cur_zero;

    // payload length up to the first zero byte, used for the overflow check
    reg  [IW-1:0] pay_len;
    integer       k;
    integer       j;
    always @* begin
        pay_len = {IW{1'b0}};
        for (k = IMG_BYTES - 1; k >= 2; k = k - 1) begin
            if (out_image[8*k +: 8] == 8'h00)
                pay_len = k[IW-1:0] - 2'd2;
        end
        if (out_image[8*IMG_BYTES-1 -: 8] != 8'h00 && pay_len == {IW{1'b0}} &&
            img2 != 8'h00)
            pay_len = DATA_BYTES[IW-1:0];
    end

    wire        fits = ({{(CW-IW){1'b0}}, pay_len} + txbuf_cnt_reg) <= BUF_BYTES[CW-1:0];
    wire        tx_take = tx_valid && tx_ready;
    // a job raised in the cycle its predecessor is taken must not be lost
    wire        host_cmd   = img0[`SGX_C0_CMD_MODE];
    wire        append_set = out_image_valid && !host_cmd && collective_sel && copy_tgl && fits;
    wire        direct_set = out_image_valid && !host_cmd && !(collective_sel && copy_tgl) &&
                             (data_chg || repeat_tgl) && img2 != 8'h00;
    wire        send_set   = out_image_valid && collective_sel && send_tgl;

    // ----------------------------------------------------------------
    // output image capture and transmit sequencer
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_control_byte_zero_reg <= `SGX_CTL_RESET;
            output_control_byte_one_reg  <= `SGX_CTL_RESET;
            out_snap_reg    <= {8*IMG_BYTES{1'b0}};
            state_reg       <= ST_IDLE;
            idx_reg         <= {IW{1'b0}};
            phase_reg       <= 2'd0;
            direct_pend_reg <= 1'b0;
            append_pend_reg <= 1'b0;
            send_pend_reg   <= 1'b0;
            cmd_pend_reg    <= 9'h000;
            cmd_idx_reg     <= 4'd0;
            txbuf_cnt_reg   <= {CW{1'b0}};
            txbuf_rd_reg    <= {CW{1'b0}};
            tx_data         <= 8'h00;
            tx_valid        <= 1'b0;
        end else begin
            if (tx_take)
                tx_valid <= 1'b0;
            if (out_image_valid) begin
                output_control_byte_zero_reg <= img0;
                output_control_byte_one_reg  <= img1;
                out_snap_reg <= out_image;
                if (img0[`SGX_C0_CMD_MODE]) begin
                    // rising bits fire commands; gate bit falling closes the gate
                    cmd_pend_reg <= cmd_pend_reg | {old2[1] & ~img2[1],
                                                    img2 & ~old2};
                end else if (collective_sel && copy_tgl) begin
                    if (fits)
                        append_pend_reg <= 1'b1;
                end else if ((data_chg || repeat_tgl) && img2 != 8'h00) begin
                    direct_pend_reg <= 1'b1;
                end
                if (collective_sel && send_tgl)
                    send_pend_reg <= 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    idx_reg   <= {{(IW-2){1'b0}}, 2'b10};
                    phase_reg <= 2'd0;
                    if (append_pend_reg) begin
                        append_pend_reg <= append_set;
                        state_reg <= ST_APPEND;
                    end else if (direct_pend_reg && !cmd_mode) begin
                        direct_pend_reg <= direct_set;
                        state_reg <= ST_DIRECT;
                    end else if (cmd_pend_reg != 9'h000) begin
                        state_reg <= ST_CMD;
                    end else if (send_pend_reg) begin
                        send_pend_reg <= send_set;
                        txbuf_rd_reg <= {CW{1'b0}};
                        state_reg <= ST_SEND;
                    end else begin
                        direct_pend_reg <= direct_set;
                    end
                end
                ST_DIRECT: begin
                    if (!tx_valid || tx_take) begin
                        if (img_end) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            tx_data  <= img_byte(out_snap_reg, idx_reg);
                            tx_valid <= 1'b1;
                            idx_reg  <= idx_reg + 1'b1;
                        end
                    end
                end
                ST_APPEND: begin
                    if (img_end) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        txbuf[txbuf_cnt_reg[PW-1:0]] <= img_byte(out_snap_reg, idx_reg);
                        txbuf_cnt_reg <= txbuf_cnt_reg + 1'b1;
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                ST_CMD: begin
                    if (phase_reg == 2'd0 && !tx_valid) begin
                        // pick the lowest pending command
                        cmd_idx_reg <= 4'd8;
                        for (j = 8; j >= 0; j = j - 1) begin
                            if (cmd_pend_reg[j])
                                cmd_idx_reg <= j[3:0];
                        end
                        phase_reg <= 2'd1;
                        tx_data   <= `SGX_STX;
                        tx_valid  <= 1'b1;
                    end else if (phase_reg != 2'd0 && tx_take) begin
                        tx_valid  <= 1'b1;
                        phase_reg <= phase_reg + 1'b1;
                        case (phase_reg)
                            2'd1:    tx_data <= cmd_char(cmd_idx_reg);
                            2'd2:    tx_data <= `SGX_CR;
                            default: tx_data <= `SGX_LF;
                        endcase
                        if (phase_reg == 2'd3) begin
                            cmd_pend_reg[cmd_idx_reg] <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_SEND: begin
                    if (!tx_valid || tx_take) begin
                        if (txbuf_rd_reg == txbuf_cnt_reg) begin
                            txbuf_cnt_reg <= {CW{1'b0}};
                            state_reg <= ST_IDLE;
                        end else begin
                            tx_data  <= txbuf[txbuf_rd_reg[PW-1:0]];
                            tx_valid <= 1'b1;
                            txbuf_rd_reg <= txbuf_rd_reg + 1'b1;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive path: transparent gap framing or collective buffering
    // ----------------------------------------------------------------
    reg  [7:0]      rxbuf [0:BUF_BYTES-1];
    reg  [PW-1:0]   rx_wr_reg;
    reg  [PW-1:0]   rx_rd_reg;
    reg  [CW-1:0]   rx_cnt_reg;
    reg  [31:0]     gap_cnt_reg;
    reg  [IW-1:0]   tr_cnt_reg;
    reg             tr_cut_reg;
    reg  [8*DATA_BYTES-1:0] tr_data_reg;
    reg             blk_tgl_reg;
    reg             pres_reg;
    reg  [IW-1:0]   pres_idx_reg;

    wire rx_store = collective_sel && rx_valid && rx_cnt_reg != BUF_BYTES[CW-1:0];
    wire rx_pull  = pres_reg && pres_idx_reg != DATA_BYTES[IW-1:0] && rx_cnt_reg != 0;
    wire tr_keep  = !collective_sel && rx_valid && !tr_cut_reg &&
                    rx_data >= `SGX_CTRL_LIMIT && tr_cnt_reg != DATA_BYTES[IW-1:0];
    wire tr_done  = !collective_sel && tr_cnt_reg != 0 &&
                    (gap_cnt_reg == GAP_CYCLES - 1 ||
                     (rx_valid && rx_data == 8'h00 && !tr_cut_reg));

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_wr_reg    <= {PW{1'b0}};
            rx_rd_reg    <= {PW{1'b0}};
            rx_cnt_reg   <= {CW{1'b0}};
            gap_cnt_reg  <= 32'h0000_0000;
            tr_cnt_reg   <= {IW{1'b0}};
            tr_cut_reg   <= 1'b0;
            tr_data_reg  <= {8*DATA_BYTES{1'b0}};
            blk_tgl_reg  <= 1'b0;
            pres_reg     <= 1'b0;
            pres_idx_reg <= {IW{1'b0}};
            in_image     <= {8*IMG_BYTES{1'b0}};
        end else begin
            in_image[`SGX_S0_PENDING]    <= collective_sel && rx_cnt_reg != 0;
            in_image[`SGX_S0_BLOCK_RX]   <= blk_tgl_reg;
            in_image[`SGX_S0_COLLECTIVE] <= collective_sel;
            in_image[`SGX_S0_CMD_ACTIVE] <= cmd_mode;
            // collective: all bytes, framing included, go to the ring while it is not full
            if (rx_store) begin
                rxbuf[rx_wr_reg] <= rx_data;
                rx_wr_reg <= rx_wr_reg + 1'b1;
            end
            if (rx_pull)
                rx_rd_reg <= rx_rd_reg + 1'b1;
            rx_cnt_reg <= rx_cnt_reg + {{(CW-1){1'b0}}, rx_store} -
                          {{(CW-1){1'b0}}, rx_pull};
            // transparent: a quiet line longer than the gap closes the telegram
            if (collective_sel || rx_valid || tr_done)
                gap_cnt_reg <= 32'h0000_0000;
            else if (gap_cnt_reg != GAP_CYCLES - 1)
                gap_cnt_reg <= gap_cnt_reg + 1'b1;
            if (tr_keep) begin
                tr_data_reg[8*tr_cnt_reg +: 8] <= rx_data;
                tr_cnt_reg <= tr_cnt_reg + 1'b1;
            end
            // a quiet line also frees a cut left by a zero byte with nothing kept
            if (gap_cnt_reg == GAP_CYCLES - 1)
                tr_cut_reg <= 1'b0;
            if (!collective_sel && rx_valid && rx_data == 8'h00)
                tr_cut_reg <= 1'b1;
            if (tr_done) begin
                in_image[8*IMG_BYTES-1:16] <= tr_data_reg;
                in_image[15:8] <= {{(8-IW){1'b0}}, tr_cnt_reg};
                blk_tgl_reg <= ~blk_tgl_reg;
                tr_cnt_reg  <= {IW{1'b0}};
                tr_data_reg <= {8*DATA_BYTES{1'b0}};
                tr_cut_reg  <= 1'b0;
            end
            // collective: blocks move only on a read-acknowledge toggle
            if (out_image_valid && collective_sel && rack_tgl && !pres_reg) begin
                in_image[8*IMG_BYTES-1:8] <= {8*(IMG_BYTES-1){1'b0}};
                pres_idx_reg <= {IW{1'b0}};
                pres_reg <= rx_cnt_reg != 0;
            end
            if (pres_reg) begin
                if (rx_pull) begin
                    in_image[8*(pres_idx_reg+2) +: 8] <= rxbuf[rx_rd_reg];
                    pres_idx_reg <= pres_idx_reg + 1'b1;
                end else begin
                    in_image[15:8] <= {{(8-IW){1'b0}}, pres_idx_reg};
                    blk_tgl_reg <= ~blk_tgl_reg;
                    pres_reg <= 1'b0;
                end
            end
        end
    end

endmodule
`default_nettype wire
